// file: core/bsrt_device.sv
// Device end: tap controller, instruction register, selector,
// boundary chain with compress, random and count run modes.
// Assumes TCK far slower than clk_sys (several cycles per phase).
`timescale 1ns/100ps
`include "bsrt_map.svh"

module bsrt_device (
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	bsrt_tap_if.dev                     tap,
	input  wire logic [`BSRT_SEG_W-1:0] a_in,
	input  wire logic [`BSRT_SEG_W-1:0] b_in,
	input  wire logic                   byte1_a_to_b_drive_enable_n,
	input  wire logic                   byte2_a_to_b_drive_enable_n,
	input  wire logic                   byte1_b_to_a_drive_enable_n,
	input  wire logic                   byte2_b_to_a_drive_enable_n,
	output bsrt_pkg::bsrt_seg_t         a_out,
	output logic      [1:0]             a_oe,
	output bsrt_pkg::bsrt_seg_t         b_out,
	output logic      [1:0]             b_oe,
	output logic                        test_mode
);
	import bsrt_pkg::*;

	localparam int SW = 3 + 2 * `BSRT_SEG_W + 4;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic [SW-1:0] pins_q;
	logic          tck_rise;
	logic          tck_fall;
	logic          tms_s;
	logic          tdi_s;
	bsrt_seg_t     a_s;
	bsrt_seg_t     b_s;
	logic [3:0]    en_n_s;

	bsrt_sync #(
		.W (SW)
	) u_sync (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.d         ({byte2_b_to_a_drive_enable_n, byte1_b_to_a_drive_enable_n,
		             byte2_a_to_b_drive_enable_n, byte1_a_to_b_drive_enable_n,
		             b_in, a_in, tap.tdi, tap.tms, tap.tck}),
		.q         (pins_q),
		.edge_rise (tck_rise),
		.edge_fall (tck_fall)
	);

	assign tms_s  = pins_q[1];
	assign tdi_s  = pins_q[2];
	assign a_s    = pins_q[3 +: `BSRT_SEG_W];
	assign b_s    = pins_q[3 + `BSRT_SEG_W +: `BSRT_SEG_W];
	assign en_n_s = pins_q[3 + 2 * `BSRT_SEG_W +: 4];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic bsrt_tap_state_t tap_next(input bsrt_tap_state_t s, input logic m);
		unique case (s)
			BSRT_TLR:  tap_next = m ? BSRT_TLR  : BSRT_RTI;
			BSRT_RTI:  tap_next = m ? BSRT_SDR  : BSRT_RTI;
			BSRT_SDR:  tap_next = m ? BSRT_SIR  : BSRT_CDR;
			BSRT_CDR:  tap_next = m ? BSRT_E1DR : BSRT_SHDR;
			BSRT_SHDR: tap_next = m ? BSRT_E1DR : BSRT_SHDR;
			BSRT_E1DR: tap_next = m ? BSRT_UDR  : BSRT_PDR;
			BSRT_PDR:  tap_next = m ? BSRT_E2DR : BSRT_PDR;
			BSRT_E2DR: tap_next = m ? BSRT_UDR  : BSRT_SHDR;
			BSRT_UDR:  tap_next = m ? BSRT_SDR  : BSRT_RTI;
			BSRT_SIR:  tap_next = m ? BSRT_TLR  : BSRT_CIR;
			BSRT_CIR:  tap_next = m ? BSRT_E1IR : BSRT_SHIR;
			BSRT_SHIR: tap_next = m ? BSRT_E1IR : BSRT_SHIR;
			BSRT_E1IR: tap_next = m ? BSRT_UIR  : BSRT_PIR;
			BSRT_PIR:  tap_next = m ? BSRT_E2IR : BSRT_PIR;
			BSRT_E2IR: tap_next = m ? BSRT_UIR  : BSRT_SHIR;
			BSRT_UIR:  tap_next = m ? BSRT_SDR  : BSRT_RTI;
		endcase
	endfunction : tap_next

	// Zero state maps to zero, so an empty seed stays empty
	function automatic bsrt_seg_t lfsr_step(input bsrt_seg_t v);
		lfsr_step = {v[`BSRT_SEG_W-2:0], ^(v & `BSRT_POLY)};
	endfunction : lfsr_step

	function automatic bsrt_seg_t misr_step(input bsrt_seg_t v, input bsrt_seg_t d);
		misr_step = lfsr_step(v) ^ d;
	endfunction : misr_step

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	bsrt_dev_state_t cur;
	bsrt_dev_state_t next_cur;
	logic            dir_ab;
	logic            dir_ba;
	logic            run_ok;
	logic            is_count;
	logic            sel_chain;
	logic            sel_sel;
	bsrt_seg_t       in_seg;
	bsrt_seg_t       out_seg;
	bsrt_seg_t       in_pins;
	bsrt_seg_t       in_new;
	bsrt_seg_t       out_new;

	// Both bytes one way, and the same way
	assign dir_ab    = ~en_n_s[0] & ~en_n_s[1] & en_n_s[2] & en_n_s[3];
	assign dir_ba    = en_n_s[0] & en_n_s[1] & ~en_n_s[2] & ~en_n_s[3];
	assign test_mode = (cur.ir == `BSRT_IR_RUN_TEST_INSTRUCTION) & (dir_ab | dir_ba);
	assign is_count  = cur.sel == `BSRT_SEL_COUNT;
	assign run_ok    = test_mode & (is_count | cur.sel == `BSRT_SEL_RANDOM);
	assign sel_chain = cur.ir == `BSRT_IR_CHAIN;
	assign sel_sel   = cur.ir == `BSRT_IR_SELECTOR;

	// Control cells sit above both segments and never enter here
	assign in_seg  = dir_ab ? cur.chain[`BSRT_A_LSB +: `BSRT_SEG_W]
	                        : cur.chain[`BSRT_B_LSB +: `BSRT_SEG_W];
	assign out_seg = dir_ab ? cur.chain[`BSRT_B_LSB +: `BSRT_SEG_W]
	                        : cur.chain[`BSRT_A_LSB +: `BSRT_SEG_W];
	assign in_pins = dir_ab ? a_s : b_s;
	assign in_new  = misr_step(in_seg, in_pins);
	assign out_new = is_count ? out_seg + 1'b1 : lfsr_step(out_seg);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_cur = cur;
		// Rising edge: sample TMS, TDI and pins
		if (tck_rise) begin
			next_cur.tap = tap_next(cur.tap, tms_s);
			unique case (cur.tap)
				BSRT_TLR: begin
					next_cur.ir = `BSRT_IR_BYPASS;
				end
				BSRT_CIR: begin
					next_cur.ir_sh = `BSRT_IR_CAPTURE;
				end
				BSRT_SHIR: begin
					// Last bit also moves on the step into exit-1
					next_cur.ir_sh = {tdi_s, cur.ir_sh[`BSRT_IR_W-1:1]};
				end
				BSRT_CDR: begin
					next_cur.bypass = 1'b0;
					next_cur.sel_sh = cur.sel;
				end
				BSRT_SHDR: begin
					if (sel_chain) begin
						next_cur.chain = {tdi_s, cur.chain[`BSRT_CHAIN_W-1:1]};
					end else if (sel_sel) begin
						next_cur.sel_sh = {tdi_s, cur.sel_sh[`BSRT_SEL_W-1:1]};
					end else begin
						next_cur.bypass = tdi_s;
					end
				end
				BSRT_RTI: begin
					if (run_ok) begin
						if (dir_ab) begin
							next_cur.chain[`BSRT_A_LSB +: `BSRT_SEG_W] = in_new;
							next_cur.chain[`BSRT_B_LSB +: `BSRT_SEG_W] = out_new;
						end else begin
							next_cur.chain[`BSRT_B_LSB +: `BSRT_SEG_W] = in_new;
							next_cur.chain[`BSRT_A_LSB +: `BSRT_SEG_W] = out_new;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Falling edge: TDO and the pin outputs change only here
		if (tck_fall) begin
			next_cur.tdo_oe = (cur.tap == BSRT_SHIR) | (cur.tap == BSRT_SHDR);
			if (cur.tap == BSRT_SHIR) begin
				next_cur.tdo = cur.ir_sh[0];
			end else if (sel_chain) begin
				next_cur.tdo = cur.chain[0];
			end else if (sel_sel) begin
				next_cur.tdo = cur.sel_sh[0];
			end else begin
				next_cur.tdo = cur.bypass;
			end
			if (cur.tap == BSRT_UIR) begin
				next_cur.ir = cur.ir_sh;
			end
			if (cur.tap == BSRT_UDR && sel_sel) begin
				next_cur.sel = cur.sel_sh;
			end
			if (cur.tap == BSRT_UDR && sel_chain) begin
				next_cur.shadow = cur.chain;
			end
			if (cur.tap == BSRT_RTI && run_ok) begin
				if (dir_ab) begin
					next_cur.shadow[`BSRT_B_LSB +: `BSRT_SEG_W] = out_seg;
				end else begin
					next_cur.shadow[`BSRT_A_LSB +: `BSRT_SEG_W] = out_seg;
				end
			end
			if (test_mode) begin
				// Output-enable cells still set the drive state
				// Pins take the shadow as updated at this same fall, not one TCK late
				next_cur.a_out = next_cur.shadow[`BSRT_A_LSB +: `BSRT_SEG_W];
				next_cur.b_out = next_cur.shadow[`BSRT_B_LSB +: `BSRT_SEG_W];
				next_cur.a_oe  = {~next_cur.shadow[`BSRT_OE_2BA], ~next_cur.shadow[`BSRT_OE_1BA]};
				next_cur.b_oe  = {~next_cur.shadow[`BSRT_OE_2AB], ~next_cur.shadow[`BSRT_OE_1AB]};
			end else begin
				// Normal mode: transparent transceiver
				next_cur.a_out = b_s;
				next_cur.b_out = a_s;
				next_cur.a_oe  = {~en_n_s[3], ~en_n_s[2]};
				next_cur.b_oe  = {~en_n_s[1], ~en_n_s[0]};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur     <= '0;
			cur.ir  <= `BSRT_IR_BYPASS;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign tap.tdo    = cur.tdo;
	assign tap.tdo_oe = cur.tdo_oe;
	assign a_out      = cur.a_out;
	assign a_oe       = cur.a_oe;
	assign b_out      = cur.b_out;
	assign b_oe       = cur.b_oe;

endmodule : bsrt_device

// file: include/bsrt_map.svh
// Named constants for the boundary-run test port, both ends.
// Assumes one include per compile unit; guarded against repeats.
// Behaviour
// - Input cells fold pins into 18-bit signature
// - Output cells step pseudorandom pattern, drive on fall
// - All-zero pseudorandom seed stays at zero
// - Controller scans a seed before running modes; bench setup_run scans none
// - Output cells count up, input cells compress
// - One configuration serves both transfer directions
// - TDI, TMS, inputs sampled on rising edge
// - TDO and outputs change on falling edge
// - Controller changes TMS on falling edge
// - TMS low on rising edge leaves reset
// - Capture-IR loads fixed 10000001 pattern
// - TDO enabled on fall entering shift
// - One bit in and out per rise
// - TMS high on last shift ends scan
// - TDO released on fall in exit-1
// - Update-IR loads on fall; ones mean bypass
// - Shift states move data TDI to TDO
// - Selector code 011 runs compress and random
// - Selector code 111 runs compress and count
// - Mixed directions behave as bypass
// - Control cells 47-36 excluded from algorithms
`ifndef BSRT_MAP_SVH
`define BSRT_MAP_SVH

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define BSRT_IR_W        8
`define BSRT_IR_CAPTURE  8'h81
`define BSRT_IR_BYPASS   8'hff
`define BSRT_IR_RUN_TEST_INSTRUCTION     8'h0a
`define BSRT_IR_SELECTOR 8'h0e
`define BSRT_IR_CHAIN    8'h04

// ----------------------------------------
// Selector and boundary chain
// ----------------------------------------
`define BSRT_SEL_W       3
`define BSRT_SEL_RANDOM  3'b011
`define BSRT_SEL_COUNT   3'b111
`define BSRT_SEG_W       18
`define BSRT_BYTE_W      9
`define BSRT_CHAIN_W     48
`define BSRT_CTL_W       12
`define BSRT_A_LSB       18
`define BSRT_B_LSB       0
`define BSRT_CTL_LSB     36
`define BSRT_OE_1AB      47
`define BSRT_OE_2AB      46
`define BSRT_OE_1BA      45
`define BSRT_OE_2BA      44
`define BSRT_POLY        18'h20400

// ----------------------------------------
// Controller registers and timing
// ----------------------------------------
`define BSRT_REG_AW      4
`define BSRT_REG_TMS     4'h0
`define BSRT_REG_TDI     4'h1
`define BSRT_REG_CTRL    4'h2
`define BSRT_REG_TDO     4'h3
`define BSRT_VEC_W       32
`define BSRT_CNT_W       6
`define BSRT_START_BIT   31
`define BSRT_BUSY_BIT    31
`define BSRT_CLK_NS      10
`define BSRT_TCK_NS      80
`define BSRT_TCK_HALF    ((`BSRT_TCK_NS / `BSRT_CLK_NS) / 2)
`define BSRT_DIV_W       8

`endif

// file: include/bsrt_pkg.sv
// Types shared by both ends of the boundary-run test port.
// Assumes bsrt_map.svh is on the include path.
`include "bsrt_map.svh"

package bsrt_pkg;

	typedef logic [`BSRT_SEG_W-1:0]   bsrt_seg_t;
	typedef logic [`BSRT_CHAIN_W-1:0] bsrt_chain_t;
	typedef logic [`BSRT_IR_W-1:0]    bsrt_ir_t;
	typedef logic [`BSRT_SEL_W-1:0]   bsrt_sel_t;
	typedef logic [`BSRT_VEC_W-1:0]   bsrt_vec_t;

	// ----------------------------------------
	// Tap controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		BSRT_TLR  = 4'h0, BSRT_RTI  = 4'h1, BSRT_SDR  = 4'h3, BSRT_CDR  = 4'h2,
		BSRT_SHDR = 4'h6, BSRT_E1DR = 4'h7, BSRT_PDR  = 4'h5, BSRT_E2DR = 4'h4,
		BSRT_UDR  = 4'hc, BSRT_SIR  = 4'hd, BSRT_CIR  = 4'hf, BSRT_SHIR = 4'he,
		BSRT_E1IR = 4'ha, BSRT_PIR  = 4'hb, BSRT_E2IR = 4'h9, BSRT_UIR  = 4'h8
	} bsrt_tap_state_t;

	typedef enum logic [1:0] {
		BSRT_H_IDLE = 2'h0, BSRT_H_LOW = 2'h1, BSRT_H_HIGH = 2'h3
	} bsrt_host_state_t;

	typedef struct packed {
		bsrt_tap_state_t tap;
		bsrt_ir_t        ir_sh;
		bsrt_ir_t        ir;
		bsrt_sel_t       sel_sh;
		bsrt_sel_t       sel;
		logic            bypass;
		bsrt_chain_t     chain;
		bsrt_chain_t     shadow;
		logic            tdo;
		logic            tdo_oe;
		bsrt_seg_t       a_out;
		logic [1:0]      a_oe;
		bsrt_seg_t       b_out;
		logic [1:0]      b_oe;
	} bsrt_dev_state_t;

	typedef struct packed {
		bsrt_host_state_t       st;
		logic [`BSRT_DIV_W-1:0] div;
		bsrt_vec_t              tms_vec;
		bsrt_vec_t              tdi_vec;
		bsrt_vec_t              tdo_vec;
		logic [`BSRT_CNT_W-1:0] count;
		logic [`BSRT_CNT_W-1:0] left;
		logic                   tck;
		logic                   tms;
		logic                   tdi;
		bsrt_vec_t              rdata;
	} bsrt_host_state_s_t;

endpackage : bsrt_pkg

// file: include/bsrt_tap_if.sv
// Four-wire test port plus TDO enable, joining controller and device.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps

interface bsrt_tap_if;

	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;

	modport dev (
		input  tck,
		input  tms,
		input  tdi,
		output tdo,
		output tdo_oe
	);

	modport host (
		output tck,
		output tms,
		output tdi,
		input  tdo,
		input  tdo_oe
	);

endinterface : bsrt_tap_if

// file: core/bsrt_sync.sv
// Two-flop synchroniser with edge pulses for bit 0.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/100ps

module bsrt_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q,
	output logic              edge_rise,
	output logic              edge_fall
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
		logic         prev;
	} bsrt_sync_state_t;

	bsrt_sync_state_t cur;
	bsrt_sync_state_t next_cur;

	always_comb begin
		next_cur      = cur;
		next_cur.meta = d;
		next_cur.q    = cur.meta;
		next_cur.prev = cur.q[0];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Edges look only at the second stage
	assign q         = cur.q;
	assign edge_rise = cur.q[0] & ~cur.prev;
	assign edge_fall = ~cur.q[0] & cur.prev;

endmodule : bsrt_sync

// file: core/bsrt_host.sv
// Controller end: plays TMS/TDI vectors on a divided TCK, gathers TDO.
// Assumes software loads vectors, then starts; one cycle read latency.
`timescale 1ns/100ps
`include "bsrt_map.svh"

module bsrt_host #(
	parameter int TCK_HALF = `BSRT_TCK_HALF
) (
	input  wire logic                    clk_sys,
	input  wire logic                    sys_rst,
	input  wire logic [`BSRT_REG_AW-1:0] reg_addr,
	input  wire logic [`BSRT_VEC_W-1:0]  reg_wdata,
	input  wire logic                    reg_we,
	input  wire logic                    reg_re,
	output bsrt_pkg::bsrt_vec_t          reg_rdata,
	bsrt_tap_if.host                     tap
);
	import bsrt_pkg::*;

	localparam logic [`BSRT_DIV_W-1:0] HALF_LAST = `BSRT_DIV_W'(TCK_HALF - 1);

	logic [1:0]         tdo_q;
	logic               tdo_bit;
	bsrt_host_state_s_t cur;
	bsrt_host_state_s_t next_cur;

	bsrt_sync #(
		.W (2)
	) u_sync (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.d         ({tap.tdo_oe, tap.tdo}),
		.q         (tdo_q),
		.edge_rise (),
		.edge_fall ()
	);

	// Released TDO reads as zero
	assign tdo_bit = tdo_q[0] & tdo_q[1];

	// ----------------------------------------
	// Sequencer and registers
	// ----------------------------------------
	always_comb begin
		next_cur       = cur;
		next_cur.rdata = '0;
		if (reg_re) begin
			unique case (reg_addr)
				`BSRT_REG_TMS:  next_cur.rdata = cur.tms_vec;
				`BSRT_REG_TDI:  next_cur.rdata = cur.tdi_vec;
				`BSRT_REG_CTRL: next_cur.rdata = {cur.st != BSRT_H_IDLE,
				                                  {(`BSRT_VEC_W-1-`BSRT_CNT_W){1'b0}}, cur.count};
				`BSRT_REG_TDO:  next_cur.rdata = cur.tdo_vec;
				default:        next_cur.rdata = '0;
			endcase
		end
		unique case (cur.st)
			BSRT_H_IDLE: begin
				// Seed scan, reset exit and scan ends live in the vectors
				if (reg_we && reg_addr == `BSRT_REG_TMS) begin
					next_cur.tms_vec = reg_wdata;
				end
				if (reg_we && reg_addr == `BSRT_REG_TDI) begin
					next_cur.tdi_vec = reg_wdata;
				end
				if (reg_we && reg_addr == `BSRT_REG_CTRL && reg_wdata[`BSRT_START_BIT]
				    && reg_wdata[`BSRT_CNT_W-1:0] != '0) begin
					next_cur.count   = reg_wdata[`BSRT_CNT_W-1:0];
					next_cur.left    = reg_wdata[`BSRT_CNT_W-1:0];
					next_cur.tdo_vec = '0;
					next_cur.div     = '0;
					next_cur.tms     = cur.tms_vec[0];
					next_cur.tdi     = cur.tdi_vec[0];
					next_cur.st      = BSRT_H_LOW;
				end
			end
			BSRT_H_LOW: begin
				next_cur.div = cur.div + 1'b1;
				if (cur.div == HALF_LAST) begin
					next_cur.div = '0;
					next_cur.tck = 1'b1;
					next_cur.st  = BSRT_H_HIGH;
				end
			end
			BSRT_H_HIGH: begin
				next_cur.div = cur.div + 1'b1;
				if (cur.div == HALF_LAST) begin
					// TDO of this bit is settled by the fall
					next_cur.div     = '0;
					next_cur.tck     = 1'b0;
					next_cur.tdo_vec = {tdo_bit, cur.tdo_vec[`BSRT_VEC_W-1:1]};
					next_cur.tms_vec = {1'b0, cur.tms_vec[`BSRT_VEC_W-1:1]};
					next_cur.tdi_vec = {1'b0, cur.tdi_vec[`BSRT_VEC_W-1:1]};
					next_cur.left    = cur.left - 1'b1;
					next_cur.tms     = cur.tms_vec[1];
					next_cur.tdi     = cur.tdi_vec[1];
					next_cur.st      = (cur.left == `BSRT_CNT_W'(1)) ? BSRT_H_IDLE : BSRT_H_LOW;
					if (cur.left == `BSRT_CNT_W'(1)) begin
						next_cur.tms = cur.tms;
						next_cur.tdi = cur.tdi;
					end
				end
			end
			default: begin
				next_cur.st = BSRT_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign reg_rdata = cur.rdata;
	assign tap.tck   = cur.tck;
	assign tap.tms   = cur.tms;
	assign tap.tdi   = cur.tdi;

endmodule : bsrt_host

// file: verification/bsrt_monitor.sv
// Checker for the four test-port wires between controller and device.
// Assumes the controller runs with a TCK half period of 4 system clocks.
`timescale 1ns/100ps

module bsrt_monitor (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);

	logic       tck_q;
	logic [3:0] since_fall;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------
	// Cycles since TCK fell, saturating
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		tck_q <= tck;
		if (sys_rst)
			since_fall <= 4'hf;
		else if (tck_q && !tck)
			since_fall <= 4'h0;
		else if (since_fall != 4'hf)
			since_fall <= since_fall + 4'h1;
	end

	// ----------------------------------------
	// Wire relations
	// ----------------------------------------
	a_tms_moves_low: assert property ($changed(tms) |-> !tck)
		else $error("TMS moved while TCK high");
	a_tdi_moves_low: assert property ($changed(tdi) |-> !tck)
		else $error("TDI moved while TCK high");
	a_tck_high_phase: assert property ($rose(tck) |-> tck[*4] ##1 !tck)
		else $error("TCK high phase not four clocks");
	a_tck_low_phase: assert property ($fell(tck) |-> !tck[*4])
		else $error("TCK low phase shorter than four clocks");
	a_tdo_after_fall: assert property ($changed(tdo) |-> since_fall inside {[1:5]})
		else $error("TDO changed away from a TCK fall");
	a_oe_after_fall: assert property ($changed(tdo_oe) |-> since_fall inside {[1:5]})
		else $error("TDO enable changed away from a TCK fall");
	a_exit_release: assert property (($rose(tck) && tms && tdo_oe) |-> tdo_oe[*5] ##[1:5] !tdo_oe)
		else $error("TDO not released on fall after leaving shift");
	a_shift_hold: assert property (($rose(tck) && !tms && tdo_oe) |-> tdo_oe[*8])
		else $error("TDO enable dropped while still shifting");

endmodule : bsrt_monitor

// file: verification/tb.sv
// Bench joining controller and device across the test-port interface.
// Assumes bsrt_map.svh on the include path and the package compiled first.
`timescale 1ns/100ps
`include "bsrt_map.svh"

module tb;
	import bsrt_pkg::*;

	logic                    clk_sys;
	logic                    sys_rst;
	logic [`BSRT_REG_AW-1:0] reg_addr;
	bsrt_vec_t               reg_wdata;
	logic                    reg_we;
	logic                    reg_re;
	bsrt_vec_t               reg_rdata;
	bsrt_seg_t               a_in;
	bsrt_seg_t               b_in;
	bsrt_seg_t               a_out;
	bsrt_seg_t               b_out;
	logic [1:0]              a_oe;
	logic [1:0]              b_oe;
	logic [3:0]              dir_n;
	logic                    test_mode;
	int                      mismatches;
	int                      n_checks;

	bsrt_tap_if link ();

	bsrt_host #(.TCK_HALF(4)) u_bsrt_host (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .tap(link.host)
	);

	// Enable order in dir_n: byte1 AtoB, byte2 AtoB, byte1 BtoA, byte2 BtoA
	bsrt_device u_bsrt_device (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .tap(link.dev), .a_in(a_in), .b_in(b_in),
		.byte1_a_to_b_drive_enable_n(dir_n[3]), .byte2_a_to_b_drive_enable_n(dir_n[2]),
		.byte1_b_to_a_drive_enable_n(dir_n[1]), .byte2_b_to_a_drive_enable_n(dir_n[0]),
		.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .test_mode(test_mode)
	);

	bsrt_monitor u_bsrt_monitor (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .tck(link.tck), .tms(link.tms),
		.tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe)
	);

	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] addr, input bsrt_vec_t data);
		@(posedge clk_sys);
		reg_addr  <= addr;
		reg_wdata <= data;
		reg_we    <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] addr, output bsrt_vec_t data);
		@(posedge clk_sys);
		reg_addr <= addr;
		reg_re   <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		// Read data stand only until the next rising edge
		@(negedge clk_sys);
		data = reg_rdata;
	endtask : reg_rd

	// Reference step: shift left, bits 17 and 10 fed back into bit 0
	function automatic bsrt_seg_t ref_lfsr(input bsrt_seg_t v);
		ref_lfsr = {v[16:0], v[17] ^ v[10]};
	endfunction : ref_lfsr

	// Plays n TCK cycles; a stuck busy flag ends the run
	task automatic scan(input bsrt_vec_t tms, input bsrt_vec_t tdi, input logic [5:0] n, output bsrt_vec_t tdo);
		bsrt_vec_t st;
		reg_wr(`BSRT_REG_TMS, tms);
		reg_wr(`BSRT_REG_TDI, tdi);
		reg_wr(`BSRT_REG_CTRL, {1'b1, 25'h0, n});
		st = 32'h8000_0000;
		for (int i = 0; i < 400 && st[`BSRT_BUSY_BIT] !== 1'b0; i++)
			reg_rd(`BSRT_REG_CTRL, st);
		if (st[`BSRT_BUSY_BIT] !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
		reg_rd(`BSRT_REG_TDO, tdo);
		repeat (8) @(posedge clk_sys);
	endtask : scan

	// From Run-Test/Idle through one scan and back; IR path checks the capture
	task automatic shift_reg(input logic ir, input bsrt_vec_t data, input int n);
		bsrt_vec_t tdo;
		int        pre;
		pre = ir ? 4 : 3;
		scan((ir ? 32'h3 : 32'h1) | (32'h3 << (pre + n - 1)), data << pre, 6'(pre + n + 2), tdo);
		if (ir)
			chk("ir capture", 32'(tdo[29:22]), 32'h81);
	endtask : shift_reg

	task automatic run_idle(input logic [5:0] n);
		bsrt_vec_t tdo;
		scan(32'h0, 32'h0, n, tdo);
	endtask : run_idle

	task automatic setup_run(input logic [2:0] sel);
		shift_reg(1'b1, 32'(`BSRT_IR_SELECTOR), 8);
		shift_reg(1'b0, 32'(sel), 3);
		shift_reg(1'b1, 32'(`BSRT_IR_RUN_TEST_INSTRUCTION), 8);
	endtask : setup_run

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_ir_capture;
		bsrt_vec_t d;
		reg_wr(4'h9, 32'h1234_5678);
		reg_rd(4'h9, d);
		chk("unmapped read", d, 32'h0);
		run_idle(6'd1);
		shift_reg(1'b1, 32'(`BSRT_IR_BYPASS), 8);
		chk("bypass test_mode", 32'(test_mode), 32'h0);
		chk("bypass b_out", 32'(b_out), 32'(a_in));
		chk("bypass b_oe", 32'(b_oe), 32'h3);
	endtask : t_ir_capture

	// Zero seed after reset must never leave zero
	task automatic t_random_zero;
		setup_run(`BSRT_SEL_RANDOM);
		chk("random test_mode", 32'(test_mode), 32'h1);
		run_idle(6'd12);
		chk("random b_out", 32'(b_out), 32'h0);
	endtask : t_random_zero

	// Count step measured as a difference, so entry edges do not matter
	task automatic t_count;
		bsrt_seg_t first;
		bsrt_seg_t diff;
		setup_run(`BSRT_SEL_COUNT);
		for (int d = 0; d < 2; d++) begin
			dir_n <= d ? 4'b1100 : 4'b0011;
			repeat (10) @(posedge clk_sys);
			chk("count test_mode", 32'(test_mode), 32'h1);
			run_idle(6'd5);
			first = d ? a_out : b_out;
			run_idle(6'd9);
			diff = (d ? a_out : b_out) - first;
			chk("count step", 32'(diff), 32'd9);
			chk("count drive", 32'(d ? a_oe : b_oe), 32'h3);
		end
	endtask : t_count

	// Counted value left in A becomes the seed once A drives
	task automatic t_random_seed;
		bsrt_seg_t seed;
		setup_run(`BSRT_SEL_RANDOM);
		seed = a_out;
		chk("seed nonzero", 32'(seed != '0), 32'h1);
		run_idle(6'd2);
		chk("random step", 32'(a_out), 32'(ref_lfsr(ref_lfsr(seed))));
	endtask : t_random_seed

	// Second chain scan pushes the first scan's leading bits out
	task automatic t_chain;
		bsrt_vec_t tdo;
		shift_reg(1'b1, 32'(`BSRT_IR_CHAIN), 8);
		shift_reg(1'b0, 32'h0000_002d, 27);
		scan(32'h1 | (32'h3 << 29), 32'h0, 6'd32, tdo);
		chk("chain out", 32'(tdo[29:24]), 32'h2d);
	endtask : t_chain

	task automatic t_mixed;
		dir_n <= 4'b0000;
		repeat (10) @(posedge clk_sys);
		chk("mixed test_mode", 32'(test_mode), 32'h0);
		run_idle(6'd2);
		chk("mixed b_out", 32'(b_out), 32'(a_in));
		chk("mixed a_out", 32'(a_out), 32'(b_in));
	endtask : t_mixed

	initial begin
		mismatches = 0;
		n_checks   = 0;
		sys_rst   <= 1'b1;
		reg_addr  <= 4'h0;
		reg_wdata <= 32'h0;
		reg_we    <= 1'b0;
		reg_re    <= 1'b0;
		a_in      <= 18'h2a5c3;
		b_in      <= 18'h15a3c;
		dir_n     <= 4'b0011;
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_ir_capture();
		t_random_zero();
		t_count();
		t_random_seed();
		t_mixed();
		t_chain();
		wrap_up();
	end

endmodule : tb
